// >>> e3_rx_line_decoder.sv
// E3 receive line decoder: rail sampling, AMI/HDB3 decode, violation counting.
// Assumes line clock and rails arrive asynchronously; registers reached over AXI4-Lite.
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module e3_rx_line_decoder #(
    parameter int ONE_SEC_CYCLES = e3_rx_pkg::ONE_SEC_CYCLES
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic recv_line_clock_i,
    input wire logic recv_positive_rail_i,
    input wire logic recv_negative_rail_i,
    output logic recv_data_o,
    output logic recv_data_valid_o,
    output logic line_code_violation_o,
    output logic tx_single_rail_o,
    output logic irq_o,
    input wire logic [e3_rx_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [e3_rx_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    // Synchronisers
    logic [2:0] lclk_r;
    logic [2:0] lclk_ok_r;
    e3_rx_pkg::rail_t rail_s1_r;
    e3_rx_pkg::rail_t rail_s2_r;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            lclk_r <= 3'h0;
            lclk_ok_r <= 3'h0;
            rail_s1_r <= '0;
            rail_s2_r <= '0;
        end else begin
            lclk_r <= {lclk_r[1:0], recv_line_clock_i};
            lclk_ok_r <= {lclk_ok_r[1:0], 1'b1};
            rail_s1_r <= {recv_positive_rail_i, recv_negative_rail_i};
            rail_s2_r <= rail_s1_r;
        end
    end

    // Registers
    logic [7:0] ctrl_r;
    logic [1:0] sts_r;
    logic [1:0] mask_r;
    logic [15:0] evt_cnt_r;
    logic [15:0] acc_run_r;
    logic [15:0] acc_r;

    logic edge_sel;
    logic uni;
    logic ami;
    assign edge_sel = ctrl_r[e3_rx_pkg::CTRL_EDGE_BIT];
    assign uni = ctrl_r[e3_rx_pkg::CTRL_UNI_BIT];
    assign ami = ctrl_r[e3_rx_pkg::CTRL_AMI_BIT];

    // Sampling edge of the line clock
    logic rise_det;
    logic fall_det;
    logic samp;
    // Edge detect held off until the synchroniser is filled after reset
    assign rise_det = lclk_ok_r[2] & lclk_r[1] & ~lclk_r[2];
    assign fall_det = lclk_ok_r[2] & ~lclk_r[1] & lclk_r[2];
    assign samp = edge_sel ? fall_det : rise_det;

    // Symbol classification
    e3_rx_pkg::sym_t d_r [4];
    e3_rx_pkg::sym_t s_new;
    logic last_pol_r;
    logic have_mark_r;
    logic [1:0] zrun_r;
    logic dbl;
    logic viol;
    logic valid_v;
    logic line_code_violation;
    logic zero3;

    always_comb begin
        if (uni) begin
            s_new.mark = rail_s2_r.pos;
            s_new.pos = 1'b1;
        end else begin
            s_new.mark = rail_s2_r.pos | rail_s2_r.neg;
            s_new.pos = rail_s2_r.pos;
        end
    end

    assign dbl = ~uni & rail_s2_r.pos & rail_s2_r.neg;
    assign viol = ~uni & s_new.mark & ~dbl & have_mark_r & (s_new.pos == last_pol_r);
    assign valid_v = viol & ~ami & ~d_r[0].mark & ~d_r[1].mark;
    assign line_code_violation = samp & ((viol & ~valid_v) | dbl);
    assign zero3 = samp & ~uni & ~ami & ~s_new.mark & (zrun_r == (e3_rx_pkg::ZERO_RUN_LIMIT - 2'h1));

    // Four-symbol delay line, cleared whole on a valid substitution
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_dly
            e3_rx_pkg::sym_t d_prev;
            if (gi == 0) begin : g_head
                assign d_prev = s_new;
            end else begin : g_tail
                assign d_prev = d_r[gi-1];
            end
            always_ff @(posedge clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    d_r[gi] <= '0;
                end else if (samp) begin
                    if (valid_v) begin
                        d_r[gi] <= '0;
                    end else begin
                        d_r[gi] <= d_prev;
                    end
                end
            end
        end
    endgenerate

    // Polarity and zero run tracking
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            last_pol_r <= 1'b0;
            have_mark_r <= 1'b0;
            zrun_r <= 2'h0;
        end else if (samp) begin
            if (s_new.mark && !dbl && !uni) begin
                last_pol_r <= s_new.pos;
                have_mark_r <= 1'b1;
            end
            if (s_new.mark) begin
                zrun_r <= 2'h0;
            end else if (zrun_r != e3_rx_pkg::ZERO_RUN_LIMIT) begin
                zrun_r <= zrun_r + 2'h1;
            end
        end
    end

    // Decoded output stream
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            recv_data_o <= 1'b0;
            recv_data_valid_o <= 1'b0;
            line_code_violation_o <= 1'b0;
        end else begin
            recv_data_valid_o <= samp;
            line_code_violation_o <= line_code_violation;
            if (samp) begin
                recv_data_o <= d_r[3].mark;
            end
        end
    end

    // Violation event count
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            evt_cnt_r <= 16'h0000;
        end else if (line_code_violation) begin
            evt_cnt_r <= evt_cnt_r + 16'h0001;
        end
    end

    // One-second accumulation
    logic [31:0] sec_cnt_r;
    logic sec_tick;
    logic acc_inc;
    assign sec_tick = (sec_cnt_r == 32'(ONE_SEC_CYCLES - 1));
    assign acc_inc = line_code_violation | zero3;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sec_cnt_r <= 32'h0;
            acc_run_r <= 16'h0000;
            acc_r <= 16'h0000;
        end else begin
            sec_cnt_r <= sec_tick ? 32'h0 : sec_cnt_r + 32'h1;
            if (sec_tick) begin
                acc_r <= acc_run_r + {15'h0000, acc_inc};
                acc_run_r <= 16'h0000;
            end else if (acc_inc) begin
                acc_run_r <= acc_run_r + 16'h0001;
            end
        end
    end

    // AXI4-Lite write path
    logic aw_got_r;
    logic w_got_r;
    logic [6:0] wr_idx_r;
    logic [7:0] wr_byte_r;
    logic wr_be_r;
    logic aw_fire;
    logic w_fire;
    logic do_write;
    assign aw_fire = s_axi_awvalid & s_axi_awready;
    assign w_fire = s_axi_wvalid & s_axi_wready;
    assign do_write = aw_got_r & w_got_r & ~s_axi_bvalid;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            wr_idx_r <= 7'h00;
            wr_byte_r <= 8'h00;
            wr_be_r <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= e3_rx_pkg::RESP_OKAY;
        end else begin
            if (aw_fire) begin
                s_axi_awready <= 1'b0;
                aw_got_r <= 1'b1;
                wr_idx_r <= s_axi_awaddr[8:2];
            end
            if (w_fire) begin
                s_axi_wready <= 1'b0;
                w_got_r <= 1'b1;
                wr_byte_r <= s_axi_wdata[7:0];
                wr_be_r <= s_axi_wstrb[0];
            end
            if (do_write) begin
                aw_got_r <= 1'b0;
                w_got_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wr_idx_r == e3_rx_pkg::IDX_CTRL || wr_idx_r == e3_rx_pkg::IDX_STS ||
                    wr_idx_r == e3_rx_pkg::IDX_MASK) ? e3_rx_pkg::RESP_OKAY : e3_rx_pkg::RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    logic wr_ok;
    assign wr_ok = do_write & wr_be_r;

    // Control and mask registers
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl_r <= e3_rx_pkg::CTRL_RESET;
            mask_r <= e3_rx_pkg::MASK_RESET;
        end else if (wr_ok) begin
            if (wr_idx_r == e3_rx_pkg::IDX_CTRL) begin
                ctrl_r <= wr_byte_r & e3_rx_pkg::CTRL_WMASK;
            end
            if (wr_idx_r == e3_rx_pkg::IDX_MASK) begin
                mask_r <= wr_byte_r[1:0];
            end
        end
    end

    // Sticky status, set beats a write-one clear
    logic [1:0] sts_set;
    logic [1:0] sts_clr;
    assign sts_set = {zero3, line_code_violation};
    assign sts_clr = (wr_ok && wr_idx_r == e3_rx_pkg::IDX_STS) ? wr_byte_r[1:0] : 2'h0;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sts_r <= e3_rx_pkg::STS_RESET;
            irq_o <= 1'b0;
            tx_single_rail_o <= 1'b0;
        end else begin
            sts_r <= (sts_r & ~sts_clr) | sts_set;
            irq_o <= |(sts_r & mask_r);
            tx_single_rail_o <= uni;
        end
    end

    // AXI4-Lite read path
    logic [6:0] rd_idx;
    logic [31:0] rd_val;
    logic rd_hit;
    assign rd_idx = s_axi_araddr[8:2];

    always_comb begin
        rd_val = 32'h0;
        rd_hit = 1'b1;
        case (rd_idx)
            e3_rx_pkg::IDX_CTRL: rd_val = {24'h0, ctrl_r};
            e3_rx_pkg::IDX_STS: rd_val = {30'h0, sts_r};
            e3_rx_pkg::IDX_MASK: rd_val = {30'h0, mask_r};
            e3_rx_pkg::IDX_EVT_HI: rd_val = {24'h0, evt_cnt_r[15:8]};
            e3_rx_pkg::IDX_EVT_LO: rd_val = {24'h0, evt_cnt_r[7:0]};
            e3_rx_pkg::IDX_ACC_HI: rd_val = {24'h0, acc_r[15:8]};
            e3_rx_pkg::IDX_ACC_LO: rd_val = {24'h0, acc_r[7:0]};
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= e3_rx_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_val;
            s_axi_rresp <= rd_hit ? e3_rx_pkg::RESP_OKAY : e3_rx_pkg::RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // Checks
    a_edge_select: assert property (samp |->
        (edge_sel ? (lclk_r[2] && !lclk_r[1]) : (lclk_r[1] && !lclk_r[2])))
        else $error("sample taken on wrong line clock edge");
    a_uni_sample: assert property (samp && uni && !valid_v |=> d_r[0].mark == $past(rail_s2_r.pos))
        else $error("unipolar sample not taken from positive rail");
    a_uni_no_lcv: assert property (uni |-> !line_code_violation)
        else $error("violation flagged in unipolar mode");
    a_ami_viol: assert property (samp && ami && viol |=> line_code_violation_o)
        else $error("AMI violation not flagged");
    a_hdb3_zeros: assert property (samp && valid_v |=>
        (d_r[0].mark == 1'b0) && (d_r[1].mark == 1'b0) && (d_r[2].mark == 1'b0) && (d_r[3].mark == 1'b0))
        else $error("valid substitution not replaced by zeros");
    a_evt_count: assert property (line_code_violation |=> evt_cnt_r == $past(evt_cnt_r) + 16'h0001)
        else $error("event count missed a violation");
    a_acc_count: assert property (acc_inc && !sec_tick |=> acc_run_r == $past(acc_run_r) + 16'h0001)
        else $error("one-second accumulation missed an event");
    a_zero_run: assert property (samp && !uni && !ami && !s_new.mark &&
        !d_r[0].mark && !d_r[1].mark && d_r[2].mark |-> zero3)
        else $error("third zero not counted");
    a_mode_write: assert property ($changed(uni) |-> $past(wr_ok && wr_idx_r == e3_rx_pkg::IDX_CTRL))
        else $error("input mode changed without a control write");
    a_tx_mode: assert property ($changed(uni) |=> tx_single_rail_o == $past(uni))
        else $error("transmit rail mode does not follow control");
    a_irq_level: assert property ((sts_r & mask_r) != 2'h0 |=> irq_o)
        else $error("unmasked status did not raise interrupt");

endmodule

// >>> e3_rx_pkg.sv
// Constants, register map and carrier types for the E3 receive line decoder.
// Assumes a 100 MHz system clock and AXI4-Lite register access, one register per word.
// Summary of operation
// - All receive logic is timed by the recovered line clock edges, except the one-second period, which counts system clock cycles.
// - Line data is captured only from the positive and negative rail inputs.
// - Unipolar mode takes NRZ data from the positive rail alone.
// - Unipolar: rail high at sampling edge gives one, low gives zero.
// - Control bit 3 picks bipolar (0) or unipolar (1) input mode.
// - After reset the mode bit is 0, so operation is bipolar.
// - The rail format choice also drives the transmit output mode.
// - Bipolar mode accepts both rails and decodes AMI or HDB3.
// - AMI: a mark on either rail is one, no pulse is zero.
// - HDB3: 000V and B00V patterns become four zeros.
// - Invalid violations flag a code violation and bump the event count.
// - Each flagged code violation also bumps the one-second accumulation.
// - HDB3: three or more consecutive zeros bump the one-second accumulation.
// - Control bit 1 picks rising (0) or falling (1) sampling edge.
package e3_rx_pkg;

    localparam int ADDR_W = 9;
    localparam int DATA_W = 32;

    // Register indices; byte address is four times the index
    localparam logic [6:0] IDX_CTRL = 7'h01;
    localparam logic [6:0] IDX_STS = 7'h02;
    localparam logic [6:0] IDX_MASK = 7'h03;
    localparam logic [6:0] IDX_EVT_HI = 7'h50;
    localparam logic [6:0] IDX_EVT_LO = 7'h51;
    localparam logic [6:0] IDX_ACC_HI = 7'h6e;
    localparam logic [6:0] IDX_ACC_LO = 7'h6f;

    // Control register fields and reset
    localparam logic [7:0] CTRL_RESET = 8'ha0;
    localparam logic [7:0] CTRL_WMASK = 8'hbf;
    localparam int CTRL_EDGE_BIT = 1;
    localparam int CTRL_UNI_BIT = 3;
    localparam int CTRL_AMI_BIT = 4;

    // Interrupt status fields
    localparam int STS_LCV_BIT = 0;
    localparam int STS_ZERO_BIT = 1;
    localparam logic [1:0] STS_RESET = 2'h0;
    localparam logic [1:0] MASK_RESET = 2'h0;

    // Zero run that counts as excessive
    localparam logic [1:0] ZERO_RUN_LIMIT = 2'h3;

    // One-second period
    localparam int CLK_HZ = 100_000_000;
    localparam int ONE_SEC_MS = 1000;
    localparam int ONE_SEC_CYCLES = (CLK_HZ / 1000) * ONE_SEC_MS;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // One received line symbol
    typedef struct packed {
        logic mark;
        logic pos;
    } sym_t;

    // Synchronised rail pair
    typedef struct packed {
        logic pos;
        logic neg;
    } rail_t;

endpackage

// >>> line_unit_model.sv
// Line interface unit model: recovered line clock and rail data.
// Assumes the bench calls send() once per symbol and idle() between frames.
`timescale 1ns/1ps
module line_unit_model (
    input wire logic fall_sample_i,
    output logic line_clock_o,
    output logic pos_o,
    output logic neg_o
);
    initial begin
        line_clock_o = 1'b0;
        pos_o = 1'b0;
        neg_o = 1'b1;
    end
    // One 80 ns symbol, rails move on the unsampled edge
    task automatic send(input byte s);
        line_clock_o = fall_sample_i;
        pos_o = (s == "+");
        neg_o = (s == "-");
        #40 line_clock_o = ~fall_sample_i;
        #40;
    endtask
    // Clock stands still, positive rail inverts; negative rail inverts, or is driven low when single_rail is set
    task automatic idle(input logic single_rail);
        pos_o = ~pos_o;
        neg_o = single_rail ? 1'b0 : ~neg_o;
    endtask
endmodule

// >>> testbench.sv
// Self-checking bench for the E3 receive line decoder.
// Assumes the package and the line unit model are compiled first.
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
    $display("unexpected at %0t: %h vs %h", $time, g, e); end end
module testbench;
    logic clk_i, rstn_i, fall, line_clk, pos, neg;
    logic recv_data_o, recv_data_valid_o, line_code_violation_o, tx_single_rail_o, irq_o;
    logic [8:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [15:0] cnt;
    logic q[$];
    int bad_count, comparisons, lcv_n;
    typedef struct {logic [7:0] ctrl; string sym; string exp; int line_code_violation;} row_t;
    row_t rows[7];
    line_unit_model u_lu (.fall_sample_i(fall), .line_clock_o(line_clk), .pos_o(pos), .neg_o(neg));
    e3_rx_line_decoder #(.ONE_SEC_CYCLES(2000)) u_dut (
        .clk_i(clk_i), .rstn_i(rstn_i), .recv_line_clock_i(line_clk), .recv_positive_rail_i(pos),
        .recv_negative_rail_i(neg), .recv_data_o(recv_data_o), .recv_data_valid_o(recv_data_valid_o),
        .line_code_violation_o(line_code_violation_o), .tx_single_rail_o(tx_single_rail_o), .irq_o(irq_o),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready));
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // Capture of decoded bits and violation pulses
    always @(posedge clk_i) begin
        if (recv_data_valid_o === 1'b1) q.push_back(recv_data_o);
        if (line_code_violation_o === 1'b1) lcv_n++;
    end
    function automatic logic [8:0] ad(input logic [6:0] i);
        return {i, 2'b00};
    endfunction
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic tmo(input int n);
        if (n >= 50) begin
            bad_count++;
            $display("unexpected at %0t: bus timeout", $time);
            finish_test();
        end
    endtask
    task automatic axi_wr(input logic [8:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 50);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        tmo(n);
    endtask
    task automatic axi_rd(input logic [8:0] a);
        int n;
        n = 0;
        @(posedge clk_i);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 50);
        rd_d = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        tmo(n);
    endtask
    task automatic rd16(input logic [6:0] i);
        axi_rd(ad(i));
        cnt[15:8] = rd_d[7:0];
        axi_rd(ad(i + 7'h1));
        cnt[7:0] = rd_d[7:0];
    endtask
    task automatic reset_dut();
        rstn_i <= 1'b0;
        repeat (5) @(posedge clk_i);
        rstn_i <= 1'b1;
        @(posedge clk_i);
    endtask
    // Reset, set mode, send symbols plus four flushing spaces
    task automatic run(input logic [7:0] c, input string s);
        reset_dut();
        fall <= c[1];
        axi_wr(ad(e3_rx_pkg::IDX_CTRL), {24'h0, c});
        q.delete();
        lcv_n = 0;
        s = {s, "0000"};
        for (int j = 0; j < s.len(); j++) u_lu.send(s[j]);
        u_lu.idle(c[3]);
        repeat (10) @(posedge clk_i);
    endtask
    initial begin
        rows = '{'{8'hb0, "+0-0+-", "101011", 0}, '{8'hb0, "+0+", "101", 1}, '{8'ha0, "+000+", "10000", 0},
                 '{8'ha0, "+-00-", "10000", 0}, '{8'ha0, "++", "11", 1}, '{8'ha8, "+0++", "1011", 0},
                 '{8'ha2, "+0-", "101", 0}};
        {rstn_i, fall, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_awaddr = '0;
        s_axi_araddr = '0;
        s_axi_wdata = '0;
        bad_count = 0;
        comparisons = 0;
        foreach (rows[i]) begin
            run(rows[i].ctrl, rows[i].sym);
            for (int j = 0; j < rows[i].exp.len(); j++) begin
                `CHK(q[j+4], logic'(rows[i].exp[j] == "1"))
            end
            `CHK(q.size(), rows[i].exp.len() + 4)
            `CHK(lcv_n, rows[i].line_code_violation)
            rd16(e3_rx_pkg::IDX_EVT_HI);
            `CHK(cnt, 16'(rows[i].line_code_violation))
            $display("row %0d done", i);
        end
        reset_dut();
        axi_rd(ad(e3_rx_pkg::IDX_CTRL));
        `CHK(rd_d, {24'h0, e3_rx_pkg::CTRL_RESET})
        `CHK(tx_single_rail_o, 1'b0)
        axi_wr(ad(e3_rx_pkg::IDX_CTRL), 32'hff);
        axi_rd(ad(e3_rx_pkg::IDX_CTRL));
        `CHK(rd_d, 32'hbf)
        `CHK(tx_single_rail_o, 1'b1)
        axi_wr(9'h1fc, 32'h1);
        `CHK(rsp, e3_rx_pkg::RESP_SLVERR)
        axi_rd(9'h1fc);
        `CHK({rsp, rd_d}, {e3_rx_pkg::RESP_SLVERR, 32'h0})
        $display("register test done");
        run(8'ha0, "+000+--");
        axi_wr(ad(e3_rx_pkg::IDX_MASK), 32'h3);
        repeat (2) @(posedge clk_i);
        `CHK(irq_o, 1'b1)
        axi_rd(ad(e3_rx_pkg::IDX_STS));
        `CHK(rd_d, 32'h3)
        axi_wr(ad(e3_rx_pkg::IDX_MASK), 32'h0);
        repeat (2) @(posedge clk_i);
        `CHK(irq_o, 1'b0)
        axi_wr(ad(e3_rx_pkg::IDX_STS), 32'h3);
        axi_rd(ad(e3_rx_pkg::IDX_STS));
        `CHK(rd_d, 32'h0)
        rd16(e3_rx_pkg::IDX_EVT_HI);
        `CHK(cnt, 16'h1)
        repeat (2100) @(posedge clk_i);
        rd16(e3_rx_pkg::IDX_ACC_HI);
        `CHK(cnt, 16'h3)
        $display("counter test done");
        finish_test();
    end
endmodule
